/* dbol_top.sv */
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
// Functional notes
// - burst type selects sequential or interleaved reads
// - fixed chop, fixed eight, or per-command length
// - sequential wraps low bits, eight flips bit two
// - start column names first beat; interleave XORs
// - chopped read leaves last four slots undriven
// - writes ignore low bits; chop base bit two
// - fixed chop commits write two clocks earlier
// - per-command length commits at eight-beat timing
// - first read beat whole clocks after read
// - total read latency is added plus command latency
// - write recovery plus precharge sets reopen delay
// - with mask and CRC, mismatch blocks write
// - read-to-precharge plus precharge sets reopen delay
// - DLL reset bit clears itself after issue
module dbol_top (
	input wire logic clk_sys, // system clock
	input wire logic rst, // async reset, active high
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [3:0] awaddr, // write byte address
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // byte enables
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	output logic [1:0] bresp, // write response
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	input wire logic [3:0] araddr, // read byte address
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // read response
	input wire logic cmdValid, // column command offered
	output logic cmdReady, // column command taken
	input wire dbol_pkg::dbol_cmd_t cmd, // column command
	input wire logic [7:0] dqIn, // data pin input
	input wire logic dmIn, // data mask pin input
	input wire logic crcPass, // write CRC verdict
	output logic [7:0] dqOut, // data pin output
	output logic dqOe, // data pin drive enable
	output logic dqsOut, // strobe output
	output logic dqsOe, // strobe drive enable
	output logic actAllowed // bank may reopen
);
	dbol_pkg::dbol_state_t q, d;
	logic [1:0] lenSel;
	logic fixedChop;
	logic chopNow;
	logic crcGate;
	logic [5:0] totalLat;
	logic [5:0] wrDal;
	logic [5:0] rdRtp;
	logic [2:0] nextBeat;
	logic [2:0] ordCol;
	logic [31:0] rdWord;
	logic [1:0] rdResp;
	logic dllLocked;
	logic dllBusy;
	logic cmdFire;

	// byte-lane merge for register writes
	function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i * 8 +: 8] = nw[i * 8 +: 8];
			end
		end
		return r;
	endfunction

	// decoded settings
	assign lenSel = q.mode[dbol_pkg::MODE_BL_LSB +: 2];
	assign fixedChop = lenSel == dbol_pkg::BL_CHOP;
	assign chopNow = fixedChop || (lenSel == dbol_pkg::BL_PERCMD && !cmd.chopSel);
	assign crcGate = q.ctrl[dbol_pkg::CTRL_DM_BIT] && q.ctrl[dbol_pkg::CTRL_CRC_BIT];
	assign totalLat = 6'(q.lat[dbol_pkg::LAT_CL_LSB +: 5]) + 6'(q.lat[dbol_pkg::LAT_AL_LSB +: 5]);
	// reopen delays; CRC checking stretches write recovery
	assign wrDal = 6'(dbol_pkg::WR_CYC[q.mode[dbol_pkg::MODE_WR_LSB +: 3]]) + dbol_pkg::RP_CYC
		+ (crcGate ? dbol_pkg::CRC_EXTRA_CYC : 6'h00);
	assign rdRtp = 6'(q.lat[dbol_pkg::LAT_AL_LSB +: 5])
		+ 6'(dbol_pkg::RTP_CYC[q.mode[dbol_pkg::MODE_WR_LSB +: 3]]) + dbol_pkg::RP_CYC;
	assign nextBeat = (q.st == dbol_pkg::ST_RLAT) ? 3'h0 : q.beat[2:0];
	assign cmdReady = q.st == dbol_pkg::ST_IDLE && q.bankCnt == 6'h00;
	assign cmdFire = cmdValid && cmdReady;

	dbol_order u_order (
		.startCol(q.startCol),
		.beatNum(nextBeat),
		.interleaved(q.mode[dbol_pkg::MODE_BT_BIT]),
		.writeOp(q.st == dbol_pkg::ST_WDATA),
		.chop(q.chop),
		.col(ordCol)
	);

	dbol_dll u_dll (
		.clk_sys(clk_sys),
		.rst(rst),
		.start(q.dllStart),
		.locked(dllLocked),
		.busy(dllBusy)
	);

	// register read mux; unmapped words answer with an error
	always_comb begin
		rdWord = 32'h0000_0000;
		rdResp = dbol_pkg::RESP_OKAY;
		case (araddr)
			dbol_pkg::ADDR_MODE: begin
				rdWord[11:0] = q.mode;
			end
			dbol_pkg::ADDR_CTRL: begin
				rdWord[1:0] = q.ctrl;
			end
			dbol_pkg::ADDR_LAT: begin
				rdWord[9:0] = q.lat;
			end
			dbol_pkg::ADDR_STAT: begin
				rdWord[dbol_pkg::STAT_LOCK_BIT] = dllLocked;
				rdWord[dbol_pkg::STAT_DLLBUSY_BIT] = dllBusy;
				rdWord[dbol_pkg::STAT_IDLE_BIT] = q.st == dbol_pkg::ST_IDLE;
				rdWord[dbol_pkg::STAT_ACT_BIT] = q.bankCnt == 6'h00;
				rdWord[dbol_pkg::STAT_TM_BIT] = q.mode[dbol_pkg::MODE_TM_BIT];
				rdWord[dbol_pkg::STAT_BLK_LSB +: 8] = q.blocked;
			end
			default: begin
				rdResp = dbol_pkg::RESP_SLVERR;
			end
		endcase
	end

	// next state of the whole block
	always_comb begin
		d = q;
		d.dllStart = 1'b0;
		if (q.bankCnt != 6'h00) begin
			d.bankCnt = q.bankCnt - 6'h01;
		end
		// the reset bit clears itself once the request has gone out
		if (q.mode[dbol_pkg::MODE_DLL_BIT]) begin
			d.mode[dbol_pkg::MODE_DLL_BIT] = 1'b0;
			d.dllStart = 1'b1;
		end
		// address and data may arrive in either order
		if (awvalid && !q.awHave) begin
			d.awHave = 1'b1;
			d.awAddr = awaddr;
		end
		if (wvalid && !q.wHave) begin
			d.wHave = 1'b1;
			d.wData = wdata;
			d.wStrb = wstrb;
		end
		if (q.bValid && bready) begin
			d.bValid = 1'b0;
		end
		if (q.awHave && q.wHave && !q.bValid) begin
			d.awHave = 1'b0;
			d.wHave = 1'b0;
			d.bValid = 1'b1;
			d.bResp = dbol_pkg::RESP_OKAY;
			case (q.awAddr)
				dbol_pkg::ADDR_MODE: begin
					d.mode = 12'(applyStrb({20'h00000, q.mode}, q.wData, q.wStrb));
				end
				dbol_pkg::ADDR_CTRL: begin
					d.ctrl = 2'(applyStrb({30'h00000000, q.ctrl}, q.wData, q.wStrb));
				end
				dbol_pkg::ADDR_LAT: begin
					d.lat = 10'(applyStrb({22'h000000, q.lat}, q.wData, q.wStrb));
				end
				dbol_pkg::ADDR_STAT: begin
				end
				default: begin
					d.bResp = dbol_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (q.rValid && rready) begin
			d.rValid = 1'b0;
		end
		if (arvalid && !q.rValid) begin
			d.rValid = 1'b1;
			d.rData = rdWord;
			d.rResp = rdResp;
		end
		// burst engine
		case (q.st)
			dbol_pkg::ST_IDLE: begin
				if (cmdFire) begin
					d.startCol = cmd.col;
					d.chop = chopNow;
					d.autoPre = cmd.autoPre;
					d.beat = 4'h0;
					if (cmd.write) begin
						d.wmask = 8'hFF; // slots that no beat fills keep their old array data
						d.st = dbol_pkg::ST_WDATA;
					end else begin
						d.cnt = totalLat - 6'h01;
						d.st = dbol_pkg::ST_RLAT;
						if (cmd.autoPre) begin
							d.bankCnt = rdRtp;
						end
					end
				end
			end
			dbol_pkg::ST_RLAT: begin
				if (q.cnt == 6'h00) begin
					d.dqOut = q.mem[ordCol];
					d.dqOe = 1'b1;
					d.dqsOut = 1'b1;
					d.beat = 4'h1;
					d.st = dbol_pkg::ST_RBURST;
				end else begin
					d.cnt = q.cnt - 6'h01;
				end
			end
			dbol_pkg::ST_RBURST: begin
				if (q.beat == dbol_pkg::BURST_BEATS) begin
					d.dqOe = 1'b0;
					d.st = dbol_pkg::ST_IDLE;
				end else begin
					d.dqOut = q.mem[ordCol];
					d.dqOe = !(q.chop && nextBeat[2]);
					d.dqsOut = !nextBeat[0];
					d.beat = q.beat + 4'h1;
				end
			end
			dbol_pkg::ST_WDATA: begin
				// chopped writes take only the first four beats
				if (!(q.chop && q.beat[2])) begin
					d.wbuf[ordCol] = dqIn;
					d.wmask[ordCol] = dmIn && q.ctrl[dbol_pkg::CTRL_DM_BIT];
				end
				// only a fixed chop may start early, the per-command chop cannot know in time
				if (q.beat[2:0] == (fixedChop ? dbol_pkg::COMMIT_CHOP : dbol_pkg::COMMIT_EIGHT)) begin
					d.st = dbol_pkg::ST_WCOMMIT;
				end else begin
					d.beat = q.beat + 4'h1;
				end
			end
			dbol_pkg::ST_WCOMMIT: begin
				if (crcGate && !crcPass) begin
					d.blocked = q.blocked + 8'h01;
				end else begin
					for (int i = 0; i < 8; i++) begin
						if (!q.wmask[i]) begin
							d.mem[i] = q.wbuf[i];
						end
					end
				end
				if (q.autoPre) begin
					d.bankCnt = wrDal;
				end
				d.st = dbol_pkg::ST_IDLE;
			end
			default: begin
				d.st = dbol_pkg::ST_IDLE;
			end
		endcase
	end

	// all state but the DLL's lives in one register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.mode <= dbol_pkg::MODE_RST;
			q.lat <= dbol_pkg::LAT_RST;
			q.ctrl <= dbol_pkg::CTRL_RST;
			q.st <= dbol_pkg::ST_IDLE;
		end else begin
			q <= d;
		end
	end

	// outputs straight from state
	assign awready = !q.awHave;
	assign wready = !q.wHave;
	assign bvalid = q.bValid;
	assign bresp = q.bResp;
	assign arready = !q.rValid;
	assign rvalid = q.rValid;
	assign rdata = q.rData;
	assign rresp = q.rResp;
	assign dqOut = q.dqOut;
	assign dqOe = q.dqOe;
	assign dqsOut = q.dqsOut;
	assign dqsOe = q.dqOe;
	assign actAllowed = q.bankCnt == 6'h00;

	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	logic [2:0] outBeat;
	logic [2:0] seqCol;
	logic [2:0] wSlot;
	assign outBeat = q.beat[2:0] - 3'h1;
	assign seqCol = {q.startCol[2] ^ outBeat[2], 2'(q.startCol[1:0] + outBeat[1:0])};
	assign wSlot = q.chop ? {q.startCol[2], q.beat[1:0]} : q.beat[2:0];

	sequence fixedChopEarly;
		q.st == dbol_pkg::ST_WDATA && fixedChop && q.beat[2:0] == dbol_pkg::COMMIT_CHOP;
	endsequence
	sequence perCmdMid;
		q.st == dbol_pkg::ST_WDATA && lenSel == dbol_pkg::BL_PERCMD && q.beat[2:0] == dbol_pkg::COMMIT_CHOP;
	endsequence
	sequence commitThenIdle;
		q.st == dbol_pkg::ST_WCOMMIT ##1 q.st == dbol_pkg::ST_IDLE;
	endsequence

	seq_order_a: assert property (q.st == dbol_pkg::ST_RBURST && q.dqOe && !q.mode[dbol_pkg::MODE_BT_BIT]
		|-> q.dqOut == q.mem[seqCol]) else $error("sequential beat wrong");
	ilv_order_a: assert property (q.st == dbol_pkg::ST_RBURST && q.dqOe && q.mode[dbol_pkg::MODE_BT_BIT]
		|-> q.dqOut == q.mem[q.startCol ^ outBeat]) else $error("interleaved beat wrong");
	chop_hiz_a: assert property (q.st == dbol_pkg::ST_RBURST && q.chop && outBeat[2]
		|-> !dqOe && !dqsOe) else $error("chopped read drove late slot");
	write_slot_a: assert property (q.st == dbol_pkg::ST_WDATA && !(q.chop && q.beat[2])
		|=> q.wbuf[$past(wSlot)] == $past(dqIn)) else $error("write beat stored wrong");
	chop_commit_a: assert property (fixedChopEarly |=> commitThenIdle)
		else $error("fixed chop write not early");
	percmd_commit_a: assert property (perCmdMid |=> (q.st == dbol_pkg::ST_WDATA)[*2] ##1 commitThenIdle)
		else $error("per-command write not at eight-beat timing");
	read_total_a: assert property (cmdFire && !cmd.write |=> q.st == dbol_pkg::ST_RLAT
		&& q.cnt == $past(totalLat) - 6'h01) else $error("read latency not loaded");
	read_wait_a: assert property (q.st == dbol_pkg::ST_RLAT && q.cnt != 6'h00
		|=> q.st == dbol_pkg::ST_RLAT && q.cnt == $past(q.cnt) - 6'h01 && !dqOe) else $error("read wait broken");
	first_beat_a: assert property (q.st == dbol_pkg::ST_RLAT && q.cnt == 6'h00
		|=> dqOe && q.dqOut == q.mem[q.startCol]) else $error("first beat missing");
	wr_dal_a: assert property (q.st == dbol_pkg::ST_WCOMMIT && q.autoPre
		|=> q.bankCnt == $past(wrDal) && !actAllowed) else $error("write reopen delay wrong");
	crc_block_a: assert property (q.st == dbol_pkg::ST_WCOMMIT && crcGate && !crcPass
		|=> q.mem == $past(q.mem) && q.blocked == $past(q.blocked) + 8'h01) else $error("bad CRC write committed");
	rtp_dal_a: assert property (cmdFire && !cmd.write && cmd.autoPre
		|=> q.bankCnt == $past(rdRtp) && !cmdReady) else $error("read reopen delay wrong");
	dll_clear_a: assert property (q.mode[dbol_pkg::MODE_DLL_BIT]
		|=> !q.mode[dbol_pkg::MODE_DLL_BIT] ##1 dllBusy) else $error("reset bit stuck");
	chop_pick_a: assert property (cmdFire && lenSel == dbol_pkg::BL_PERCMD
		|=> q.chop == !$past(cmd.chopSel)) else $error("per-command length wrong");
endmodule // dbol_top

/* dbol_pkg.sv */
package dbol_pkg;
	// register byte offsets
	localparam logic [3:0] ADDR_MODE = 4'h0;
	localparam logic [3:0] ADDR_CTRL = 4'h4;
	localparam logic [3:0] ADDR_STAT = 4'h8;
	localparam logic [3:0] ADDR_LAT = 4'hC;
	// field positions
	localparam int MODE_BL_LSB = 0;
	localparam int MODE_BT_BIT = 3;
	localparam int MODE_TM_BIT = 7;
	localparam int MODE_DLL_BIT = 8;
	localparam int MODE_WR_LSB = 9;
	localparam int LAT_CL_LSB = 0;
	localparam int LAT_AL_LSB = 5;
	localparam int CTRL_DM_BIT = 0;
	localparam int CTRL_CRC_BIT = 1;
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_DLLBUSY_BIT = 1;
	localparam int STAT_IDLE_BIT = 2;
	localparam int STAT_ACT_BIT = 3;
	localparam int STAT_TM_BIT = 4;
	localparam int STAT_BLK_LSB = 8;
	// reset values
	localparam logic [11:0] MODE_RST = 12'h000;
	localparam logic [9:0] LAT_RST = 10'h00A;
	localparam logic [1:0] CTRL_RST = 2'h0;
	// burst length codes and beat points
	localparam logic [1:0] BL_EIGHT = 2'h0;
	localparam logic [1:0] BL_PERCMD = 2'h1;
	localparam logic [1:0] BL_CHOP = 2'h2;
	localparam logic [3:0] BURST_BEATS = 4'h8;
	localparam logic [2:0] COMMIT_EIGHT = 3'h7;
	localparam logic [2:0] WR_EARLY_CLKS = 3'h2;
	localparam logic [2:0] COMMIT_CHOP = COMMIT_EIGHT - WR_EARLY_CLKS;
	// cycles per write recovery / read-to-precharge code, code 7 reserved
	localparam logic [7:0][4:0] WR_CYC = {5'h00, 5'h18, 5'h14, 5'h12, 5'h10, 5'h0E, 5'h0C, 5'h0A};
	localparam logic [7:0][4:0] RTP_CYC = {5'h00, 5'h0C, 5'h0A, 5'h09, 5'h08, 5'h07, 5'h06, 5'h05};
	// timing
	localparam int CLK_NS = 40;
	localparam int RP_NS = 15;
	localparam logic [5:0] RP_CYC = 6'((RP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [5:0] CRC_EXTRA_CYC = 6'h02;
	localparam int DLL_LOCK_CYC = 768;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RLAT = 5'h02,
		ST_RBURST = 5'h04,
		ST_WDATA = 5'h08,
		ST_WCOMMIT = 5'h10
	} dbol_fsm_t;

	typedef struct packed {
		logic write;
		logic [2:0] col;
		logic chopSel;
		logic autoPre;
	} dbol_cmd_t;

	typedef struct packed {
		logic awHave;
		logic [3:0] awAddr;
		logic wHave;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
		logic [11:0] mode;
		logic [1:0] ctrl;
		logic [9:0] lat;
		dbol_fsm_t st;
		logic [5:0] cnt;
		logic [3:0] beat;
		logic [2:0] startCol;
		logic chop;
		logic autoPre;
		logic [7:0][7:0] mem;
		logic [7:0][7:0] wbuf;
		logic [7:0] wmask;
		logic [7:0] dqOut;
		logic dqOe;
		logic dqsOut;
		logic [5:0] bankCnt;
		logic [7:0] blocked;
		logic dllStart;
	} dbol_state_t;

	typedef struct packed {
		logic busy;
		logic locked;
		logic [9:0] cnt;
	} dbol_dll_state_t;
endpackage

/* dbol_order.sv */
`timescale 1ns/1ns
module dbol_order (
	input wire logic [2:0] startCol, // column of first beat
	input wire logic [2:0] beatNum, // beat slot 0..7
	input wire logic interleaved, // burst type
	input wire logic writeOp, // write ordering
	input wire logic chop, // four-beat burst
	output logic [2:0] col // column for this slot
);
	// writes ignore low bits; sequential reads wrap the low two bits and flip bit two for the last four beats, interleaved reads XOR
	always_comb begin
		if (writeOp) begin
			col = chop ? {startCol[2], beatNum[1:0]} : beatNum;
		end else if (interleaved) begin
			col = startCol ^ beatNum;
		end else begin
			col = {startCol[2] ^ beatNum[2], 2'(startCol[1:0] + beatNum[1:0])};
		end
	end
endmodule // dbol_order

/* dbol_dll.sv */
`timescale 1ns/1ns
module dbol_dll #(
	parameter int LOCK_CYC = dbol_pkg::DLL_LOCK_CYC // lock wait in clocks
) (
	input wire logic clk_sys, // system clock
	input wire logic rst, // async reset, active high
	input wire logic start, // one-cycle reset request
	output logic locked, // lock wait finished
	output logic busy // lock wait running
);
	dbol_pkg::dbol_dll_state_t q, d;

	// a new request restarts the wait; lock drops until it ends
	always_comb begin
		d = q;
		if (start) begin
			d.busy = 1'b1;
			d.locked = 1'b0;
			d.cnt = 10'(LOCK_CYC - 1);
		end else if (q.busy) begin
			if (q.cnt == 10'h000) begin
				d.busy = 1'b0;
				d.locked = 1'b1;
			end else begin
				d.cnt = q.cnt - 10'h001;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign locked = q.locked;
	assign busy = q.busy;

	dll_restart_a: assert property (@(posedge clk_sys) disable iff (rst) start |=> busy && !locked)
		else $error("lock wait did not restart");
endmodule // dbol_dll

/* dbol_ctrl_model.sv */
`timescale 1ns/1ns
// controller side of the column command port, one command at a time
module dbol_ctrl_model (
	input wire logic clk_sys, // system clock
	input wire logic cmdReady, // command taken when high
	input wire logic [7:0] dqOut, // read data pins
	input wire logic dqOe, // data drive enable
	input wire logic dqsOe, // strobe drive enable
	input wire logic dqsOut, // strobe level
	input wire logic actAllowed, // bank may reopen
	output logic cmdValid, // command offered
	output dbol_pkg::dbol_cmd_t cmd, // command fields
	output logic [7:0] dqIn, // write data pins
	output logic dmIn, // write mask pin
	output logic crcPass // write crc verdict
);
	logic [63:0] rd; // captured read beats
	logic [7:0] dqs; // captured strobe level per beat
	logic [9:0] oe; // drive window, slot before beat 0 up to slot after beat 7
	int busy; // cycles cmdReady stayed low
	int actLow; // cycles reopen was held off
	// idle lines carry a known pattern, never a stale beat
	initial begin
		cmdValid = 1'b0;
		cmd = '0;
		dqIn = 8'hA5;
		dmIn = 1'b0;
		crcPass = 1'b1;
	end
	// offer, hold until taken, then for 60 cycles stream beats and watch the answer
	task automatic issue(input dbol_pkg::dbol_cmd_t c, input logic [63:0] wd, input logic [7:0] dm,
		input logic crc, input int t);
		int s;
		int m;
		cmdValid <= 1'b1;
		cmd <= c;
		crcPass <= crc;
		do @(posedge clk_sys); while (cmdReady !== 1'b1);
		cmdValid <= 1'b0;
		dqIn <= wd[7:0];
		dmIn <= dm[0];
		rd = '0;
		dqs = '0;
		oe = '0;
		busy = 0;
		actLow = 0;
		for (m = 1; m <= 60; m++) begin
			@(posedge clk_sys);
			s = m - 1 - t;
			// strobe enable must track data enable, otherwise the slot reads unknown
			if (s >= -1 && s <= 8)
				oe[s + 1] = (dqOe === dqsOe) ? dqOe : 1'bx;
			if (s >= 0 && s < 8) begin
				rd[8 * s +: 8] = dqOut;
				dqs[s] = dqsOut;
			end
			if (busy == m - 1 && cmdReady !== 1'b1)
				busy = m;
			if (actAllowed !== 1'b1)
				actLow++;
			// released lines toggle so a late sample cannot look valid
			if (c.write && m < 8) begin
				dqIn <= wd[8 * m +: 8];
				dmIn <= dm[m];
			end else begin
				dqIn <= ~dqIn;
				dmIn <= ~dmIn;
			end
		end
	endtask
endmodule // dbol_ctrl_model

/* tb_top.sv */
`timescale 1ns/1ns
module tb_top;
	logic clk_sys, rst, awvalid, wvalid, bready, arvalid, rready;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, v;
	logic [1:0] bresp, rresp, rr;
	logic awready, wready, bvalid, arready, rvalid;
	logic cmdReady, cmdValid, dmIn, crcPass, dqOe, dqsOut, dqsOe, actAllowed;
	logic [7:0] dqIn, dqOut;
	logic [7:0] mem [8];
	dbol_pkg::dbol_cmd_t cmd;
	int n_fail, total_checks, e8;
	int a [5];

	dbol_top dut_u (.clk_sys, .rst, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
		.bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
		.cmdValid, .cmdReady, .cmd, .dqIn, .dmIn, .crcPass, .dqOut, .dqOe, .dqsOut, .dqsOe, .actAllowed);
	dbol_ctrl_model ctl_u (.clk_sys, .cmdReady, .dqOut, .dqOe, .dqsOe, .dqsOut, .actAllowed,
		.cmdValid, .cmd, .dqIn, .dmIn, .crcPass);

	// 25 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// hang guard, far above the few thousand cycles the run needs
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		report_and_stop();
	end

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [3:0] ad, input logic [31:0] d);
		awvalid <= 1'b1;
		awaddr <= ad;
		wvalid <= 1'b1;
		wdata <= d;
		do begin
			@(posedge clk_sys);
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		// only word-aligned offsets are mapped
		chk("bresp", 64'((ad[1:0] == 2'h0) ? dbol_pkg::RESP_OKAY : dbol_pkg::RESP_SLVERR), 64'(bresp));
	endtask

	task automatic axi_rd(input logic [3:0] ad, output logic [31:0] d);
		arvalid <= 1'b1;
		araddr <= ad;
		do @(posedge clk_sys); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk_sys); while (rvalid !== 1'b1);
		d = rdata;
		rr = rresp;
	endtask

	task automatic regchk(input string nm, input logic [3:0] ad, input logic [31:0] e);
		logic [31:0] d;
		axi_rd(ad, d);
		chk(nm, 64'(e), 64'(d));
		chk("rresp", 64'((ad[1:0] == 2'h0) ? dbol_pkg::RESP_OKAY : dbol_pkg::RESP_SLVERR), 64'(rr));
	endtask

	// expected beats worked out from the start column and burst type
	function automatic logic [63:0] exp_burst(input logic [2:0] c, input logic il);
		logic [2:0] i3;
		logic [2:0] k;
		exp_burst = '0;
		for (int i = 0; i < 8; i++) begin
			i3 = 3'(i);
			k = il ? (c ^ i3) : {c[2] ^ i3[2], 2'(c[1:0] + i3[1:0])};
			exp_burst[8 * i +: 8] = mem[k];
		end
	endfunction

	task automatic rdc(input logic [2:0] c, input logic sel, input logic il, input logic ch, input int t);
		logic [63:0] e;
		ctl_u.issue({1'b0, c, sel, 1'b0}, '0, '0, 1'b1, t);
		e = exp_burst(c, il);
		if (ch) begin
			chk("chop beats", {32'h0, e[31:0]}, {32'h0, ctl_u.rd[31:0]});
			chk("chop drive", 64'h01E, 64'(ctl_u.oe));
			chk("chop strobe", 64'h05, 64'(ctl_u.dqs[3:0]));
		end else begin
			chk("burst beats", e, ctl_u.rd);
			chk("burst drive", 64'h1FE, 64'(ctl_u.oe));
			chk("burst strobe", 64'h55, 64'(ctl_u.dqs));
		end
	endtask

	initial begin
		rst = 1'b1;
		awvalid = 1'b0;
		wvalid = 1'b0;
		arvalid = 1'b0;
		awaddr = 4'h0;
		araddr = 4'h0;
		wdata = 32'h0;
		wstrb = 4'hF;
		bready = 1'b1;
		rready = 1'b1;
		n_fail = 0;
		total_checks = 0;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		// reset values, status ignores writes
		regchk("mode rst", dbol_pkg::ADDR_MODE, 32'h0);
		regchk("ctrl rst", dbol_pkg::ADDR_CTRL, 32'h0);
		regchk("lat rst", dbol_pkg::ADDR_LAT, 32'h0000000A);
		axi_wr(dbol_pkg::ADDR_STAT, 32'hFFFFFFFF);
		axi_wr(4'h6, 32'hFFFFFFFF);
		regchk("stat rst", dbol_pkg::ADDR_STAT, 32'h0000000C);
		regchk("unmapped", 4'h2, 32'h0);
		$display("test registers done");
		// dll reset bit clears itself; no read until lock
		axi_wr(dbol_pkg::ADDR_MODE, 32'h00000100);
		regchk("dll bit", dbol_pkg::ADDR_MODE, 32'h0);
		v = 32'h0;
		for (int i = 0; i < 1000 && v[0] !== 1'b1; i++)
			axi_rd(dbol_pkg::ADDR_STAT, v);
		chk("dll lock", 64'h1, 64'(v[0]));
		$display("test dll done");
		// eight-beat write ignores the column, read back at reset latency
		ctl_u.issue({1'b1, 3'h3, 2'h0}, 64'h3736353433323130, 8'h00, 1'b1, 0);
		e8 = ctl_u.busy;
		for (int i = 0; i < 8; i++)
			mem[i] = 8'h30 + 8'(i);
		rdc(3'h0, 1'b1, 1'b0, 1'b0, 10);
		// shorter latency, every start column in both orders
		axi_wr(dbol_pkg::ADDR_LAT, 32'h00000045);
		for (int i = 0; i < 16; i++) begin
			axi_wr(dbol_pkg::ADDR_MODE, 32'(i / 8 * 8));
			rdc(3'(i), 1'b1, 1'(i / 8), 1'b0, 7);
		end
		$display("test read order done");
		// fixed chop: four beats, writes land in the half picked by bit 2
		axi_wr(dbol_pkg::ADDR_MODE, 32'h0000000A);
		rdc(3'h6, 1'b1, 1'b1, 1'b1, 7);
		axi_wr(dbol_pkg::ADDR_MODE, 32'h00000002);
		rdc(3'h5, 1'b1, 1'b0, 1'b1, 7);
		ctl_u.issue({1'b1, 3'h6, 2'h0}, 64'h4B4A4948, 8'h00, 1'b1, 0);
		chk("chop commit", 64'(e8 - 2), 64'(ctl_u.busy));
		for (int i = 4; i < 8; i++)
			mem[i] = 8'h44 + 8'(i);
		// per-command length: select low chops, high gives eight
		axi_wr(dbol_pkg::ADDR_MODE, 32'h00000001);
		rdc(3'h2, 1'b0, 1'b0, 1'b1, 7);
		rdc(3'h2, 1'b1, 1'b0, 1'b0, 7);
		ctl_u.issue({1'b1, 3'h1, 2'h0}, 64'h5B5A5958, 8'h00, 1'b1, 0);
		chk("otf commit", 64'(e8), 64'(ctl_u.busy));
		for (int i = 0; i < 4; i++)
			mem[i] = 8'h58 + 8'(i);
		rdc(3'h0, 1'b1, 1'b0, 1'b0, 7);
		$display("test length modes done");
		// masked beats dropped; with mask and crc a bad check blocks all
		axi_wr(dbol_pkg::ADDR_MODE, 32'h0);
		axi_wr(dbol_pkg::ADDR_CTRL, 32'h00000001);
		ctl_u.issue({1'b1, 5'h0}, 64'h6766656463626160, 8'h0F, 1'b1, 0);
		for (int i = 4; i < 8; i++)
			mem[i] = 8'h60 + 8'(i);
		axi_wr(dbol_pkg::ADDR_CTRL, 32'h00000003);
		ctl_u.issue({1'b1, 5'h0}, 64'h7777777777777777, 8'h00, 1'b0, 0);
		regchk("blocked", dbol_pkg::ADDR_STAT, 32'h0000010D);
		rdc(3'h0, 1'b1, 1'b0, 1'b0, 7);
		$display("test crc done");
		// reopen delay by recovery code, crc extra, read-to-precharge code
		for (int i = 0; i < 5; i++) begin
			axi_wr(dbol_pkg::ADDR_CTRL, (i == 2) ? 32'h3 : 32'h0);
			axi_wr(dbol_pkg::ADDR_MODE, (i == 1 || i == 2) ? 32'h200 : (i == 4) ? 32'hC00 : 32'h0);
			ctl_u.issue({i < 3, 5'h01}, 64'h0, 8'h00, 1'b1, 7);
			a[i] = ctl_u.actLow;
		end
		chk("wr recovery", 64'(a[0] + 2), 64'(a[1]));
		chk("crc recovery", 64'(a[1] + 2), 64'(a[2]));
		chk("rd to pre", 64'(a[3] + 7), 64'(a[4]));
		$display("test reopen done");
		report_and_stop();
	end
endmodule // tb_top
